// >>> verilog/hdc_pkg.sv
package hdc_pkg;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_TRACK = 12'h030;
  localparam logic [ADDR_W-1:0] OFS_LOCKDIS = 12'h034;
  localparam logic [ADDR_W-1:0] OFS_TRIP = 12'h038;
  localparam logic [ADDR_W-1:0] OFS_MANDAC = 12'h03C;
  localparam logic [ADDR_W-1:0] OFS_XTAL = 12'h040;
  localparam logic [ADDR_W-1:0] OFS_DACRB = 12'h05C;
  localparam logic [ADDR_W-1:0] OFS_FILTER = 12'h060;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h080;
  localparam int P_TRACK = 8;
  localparam int P_LOCKDIS = 15;
  localparam int P_PINTYPE = 24;
  localparam int P_BUF1 = 21;
  localparam int P_BUF0 = 20;
  localparam int P_UPTRIP = 14;
  localparam int P_LOTRIP = 6;
  localparam int P_RAILEN = 5;
  localparam int P_MANVAL = 22;
  localparam int P_MANEN = 20;
  localparam int P_EXITCNT = 6;
  localparam int P_FORCE = 5;
  localparam int P_XTAL = 30;
  localparam int P_DACRB = 14;
  localparam int P_C4 = 28;
  localparam int P_C3 = 24;
  localparam int P_R4 = 20;
  localparam int P_R3 = 16;
  localparam logic [13:0] PINTYPE_MAX = 14'h0006;
  localparam logic [13:0] CAP_MAX = 14'h000D;
  localparam logic [13:0] RES_MAX = 14'h0004;
  localparam logic [13:0] CNT_MIN = 14'h0001;
  localparam logic [13:0] CNT_MAX = 14'h3FFF;
  localparam logic [13:0] CNT_RESET = 14'h0001;
  localparam logic [10:0] DAC_SPAN = 11'h400;

  typedef enum logic [1:0] {
    HDC_TRACK = 2'b01,
    HDC_HOLD = 2'b10
  } hdc_mode_e;

  typedef struct packed {
    logic [2:0] pinType;
    logic bufSel1;
    logic bufSel0;
    logic [5:0] upperTrip;
    logic [5:0] lowerTrip;
    logic railDetEn;
    logic [9:0] manualDac;
    logic manualEn;
    logic [13:0] exitCount;
    logic forceHold;
    logic trackEn;
    logic lockLossDis;
    logic [1:0] xtalLvl;
    logic [3:0] capC4;
    logic [3:0] capC3;
    logic [2:0] resR4;
    logic [2:0] resR3;
  } hdc_cfg_s;

  localparam hdc_cfg_s CFG_RESET = '{exitCount: CNT_RESET, default: '0};
endpackage

// >>> verilog/hdc_trip_detect.sv
`timescale 1ns/10ps
// Compares the DAC count with both trip levels, one step = 1/64 supply.
module hdc_trip_detect
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [9:0] dacCount,
  input wire logic [5:0] upperTrip,
  input wire logic [5:0] lowerTrip,
  output logic lowFlag,
  output logic highFlag
);
  typedef struct packed {
    logic low;
    logic high;
  } hdc_trip_s;

  hdc_trip_s s_d;
  hdc_trip_s s_q;
  logic [10:0] loThr;
  logic [10:0] hiThr;

  always_comb
  begin
    loThr = {({5'h00, lowerTrip} + 11'h001) << 4};
    hiThr = hdc_pkg::DAC_SPAN - (({5'h00, upperTrip} + 11'h001) << 4);
    s_d.low = {1'b0, dacCount} <= loThr;
    s_d.high = {1'b0, dacCount} >= hiThr;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign lowFlag = s_q.low;
  assign highFlag = s_q.high;
endmodule // hdc_trip_detect

// >>> verilog/hdc_lock_qual.sv
`timescale 1ns/10ps
// Counts phase-detector ticks while the lock flag stays high.
module hdc_lock_qual
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic lockFlag,
  input wire logic pdTick,
  input wire logic [13:0] exitCount,
  output logic qualified
);
  typedef struct packed {
    logic [13:0] cnt;
    logic qual;
  } hdc_qual_s;

  hdc_qual_s s_d;
  hdc_qual_s s_q;

  always_comb
  begin
    s_d = s_q;
    if (!lockFlag)
    begin
      s_d.cnt = '0;
    end
    else if (pdTick && s_q.cnt != hdc_pkg::CNT_MAX)
    begin
      s_d.cnt = s_q.cnt + 14'h0001;
    end
    s_d.qual = lockFlag && (s_d.cnt >= exitCount);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign qualified = s_q.qual;
endmodule // hdc_lock_qual

// >>> verilog/hdc_holdover_dac_config_bank.sv
// The register addresses and the APB register port were decided locally.
`timescale 1ns/10ps
module hdc_holdover_dac_config_bank
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [hdc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic refLoopLockFlag,
  input wire logic pdTick,
  input wire logic [9:0] trackedDac,
  output hdc_pkg::hdc_cfg_s cfgOut,
  output logic [9:0] dacValue,
  output logic holdoverActive,
  output logic switchEvent,
  output logic dacLowFlag,
  output logic dacHighFlag
);
  typedef struct packed {
    hdc_pkg::hdc_cfg_s cfg;
    hdc_pkg::hdc_mode_e mode;
    logic [9:0] dac;
    logic lockPrev;
    logic railPrev;
    logic swEvt;
    logic [31:0] rdata;
  } hdc_state_s;

  hdc_state_s s_d;
  hdc_state_s s_q;
  logic lowFlag;
  logic highFlag;
  logic lockQualified;
  logic railTrip;
  logic railRise;
  logic lockFall;
  logic wrAcc;
  logic setup;

  function automatic logic mapped(input logic [hdc_pkg::ADDR_W-1:0] a);
    mapped = (a == hdc_pkg::OFS_TRACK) || (a == hdc_pkg::OFS_LOCKDIS) ||
             (a == hdc_pkg::OFS_TRIP) || (a == hdc_pkg::OFS_MANDAC) ||
             (a == hdc_pkg::OFS_XTAL) || (a == hdc_pkg::OFS_DACRB) ||
             (a == hdc_pkg::OFS_FILTER) || (a == hdc_pkg::OFS_STATUS);
  endfunction

  function automatic logic writable(input logic [hdc_pkg::ADDR_W-1:0] a);
    writable = mapped(a) && (a != hdc_pkg::OFS_DACRB) &&
               (a != hdc_pkg::OFS_STATUS);
  endfunction

  // Returns the new code if legal, else the old one.
  function automatic logic [13:0] keep(input logic [13:0] nv,
                                       input logic [13:0] old,
                                       input logic [13:0] lo,
                                       input logic [13:0] hi);
    keep = (nv < lo || nv > hi) ? old : nv;
  endfunction

  hdc_trip_detect u_trip
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .dacCount(s_q.dac),
    .upperTrip(s_q.cfg.upperTrip),
    .lowerTrip(s_q.cfg.lowerTrip),
    .lowFlag(lowFlag),
    .highFlag(highFlag)
  );

  hdc_lock_qual u_qual
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .lockFlag(refLoopLockFlag),
    .pdTick(pdTick),
    .exitCount(s_q.cfg.exitCount),
    .qualified(lockQualified)
  );

  assign wrAcc = psel && penable && pwrite && writable(paddr);
  assign setup = psel && !penable;
  assign railTrip = lowFlag || highFlag;
  assign railRise = s_q.cfg.railDetEn && railTrip && !s_q.railPrev;
  assign lockFall = s_q.lockPrev && !refLoopLockFlag;

  always_comb
  begin
    s_d = s_q;
    s_d.swEvt = 1'b0;
    s_d.lockPrev = refLoopLockFlag;
    s_d.railPrev = s_q.cfg.railDetEn && railTrip;
    if (wrAcc)
    begin
      unique case (paddr)
        hdc_pkg::OFS_TRACK:
        begin
          s_d.cfg.trackEn = pwdata[hdc_pkg::P_TRACK];
        end
        hdc_pkg::OFS_LOCKDIS:
        begin
          s_d.cfg.lockLossDis = pwdata[hdc_pkg::P_LOCKDIS];
        end
        hdc_pkg::OFS_TRIP:
        begin
          s_d.cfg.pinType = 3'(keep({11'h000, pwdata[hdc_pkg::P_PINTYPE +: 3]},
                                 {11'h000, s_q.cfg.pinType}, 14'h0000,
                                 hdc_pkg::PINTYPE_MAX));
          s_d.cfg.bufSel1 = pwdata[hdc_pkg::P_BUF1];
          s_d.cfg.bufSel0 = pwdata[hdc_pkg::P_BUF0];
          s_d.cfg.upperTrip = pwdata[hdc_pkg::P_UPTRIP +: 6];
          s_d.cfg.lowerTrip = pwdata[hdc_pkg::P_LOTRIP +: 6];
          s_d.cfg.railDetEn = pwdata[hdc_pkg::P_RAILEN];
        end
        hdc_pkg::OFS_MANDAC:
        begin
          s_d.cfg.manualDac = pwdata[hdc_pkg::P_MANVAL +: 10];
          s_d.cfg.manualEn = pwdata[hdc_pkg::P_MANEN];
          s_d.cfg.exitCount = keep(pwdata[hdc_pkg::P_EXITCNT +: 14],
                                   s_q.cfg.exitCount, hdc_pkg::CNT_MIN,
                                   hdc_pkg::CNT_MAX);
          s_d.cfg.forceHold = pwdata[hdc_pkg::P_FORCE];
        end
        hdc_pkg::OFS_XTAL:
        begin
          s_d.cfg.xtalLvl = pwdata[hdc_pkg::P_XTAL +: 2];
        end
        hdc_pkg::OFS_FILTER:
        begin
          s_d.cfg.capC4 = 4'(keep({10'h000, pwdata[hdc_pkg::P_C4 +: 4]},
                               {10'h000, s_q.cfg.capC4}, 14'h0000,
                               hdc_pkg::CAP_MAX));
          s_d.cfg.capC3 = 4'(keep({10'h000, pwdata[hdc_pkg::P_C3 +: 4]},
                               {10'h000, s_q.cfg.capC3}, 14'h0000,
                               hdc_pkg::CAP_MAX));
          s_d.cfg.resR4 = 3'(keep({11'h000, pwdata[hdc_pkg::P_R4 +: 3]},
                               {11'h000, s_q.cfg.resR4}, 14'h0000,
                               hdc_pkg::RES_MAX));
          s_d.cfg.resR3 = 3'(keep({11'h000, pwdata[hdc_pkg::P_R3 +: 3]},
                               {11'h000, s_q.cfg.resR3}, 14'h0000,
                               hdc_pkg::RES_MAX));
        end
        default:
        begin
          s_d.cfg = s_q.cfg;
        end
      endcase
    end

    // Lock loss with lockLossDis clear, or a rail trip with railDetEn set, each
    // raise one switch pulse; forcing alone does not.
    s_d.swEvt = railRise || (lockFall && !s_q.cfg.lockLossDis);

    unique case (s_q.mode)
      hdc_pkg::HDC_TRACK:
      begin
        if (s_q.cfg.forceHold || railRise ||
            (lockFall && !s_q.cfg.lockLossDis))
        begin
          s_d.mode = hdc_pkg::HDC_HOLD;
        end
      end
      hdc_pkg::HDC_HOLD:
      begin
        if (!s_q.cfg.forceHold && lockQualified &&
            !(s_q.cfg.railDetEn && railTrip))
        begin
          s_d.mode = hdc_pkg::HDC_TRACK;
        end
      end
      default:
      begin
        s_d.mode = hdc_pkg::HDC_TRACK;
      end
    endcase

    // Manual wins in any mode; tracking only follows outside holdover.
    if (s_q.cfg.manualEn)
    begin
      s_d.dac = s_q.cfg.manualDac;
    end
    else if (s_q.cfg.trackEn && s_q.mode == hdc_pkg::HDC_TRACK)
    begin
      s_d.dac = trackedDac;
    end
    else
    begin
      s_d.dac = s_q.dac;
    end

    if (setup)
    begin
      s_d.rdata = 32'h0000_0000;
      unique case (paddr)
        hdc_pkg::OFS_TRACK:
        begin
          s_d.rdata[hdc_pkg::P_TRACK] = s_q.cfg.trackEn;
        end
        hdc_pkg::OFS_LOCKDIS:
        begin
          s_d.rdata[hdc_pkg::P_LOCKDIS] = s_q.cfg.lockLossDis;
        end
        hdc_pkg::OFS_TRIP:
        begin
          s_d.rdata[hdc_pkg::P_PINTYPE +: 3] = s_q.cfg.pinType;
          s_d.rdata[hdc_pkg::P_BUF1] = s_q.cfg.bufSel1;
          s_d.rdata[hdc_pkg::P_BUF0] = s_q.cfg.bufSel0;
          s_d.rdata[hdc_pkg::P_UPTRIP +: 6] = s_q.cfg.upperTrip;
          s_d.rdata[hdc_pkg::P_LOTRIP +: 6] = s_q.cfg.lowerTrip;
          s_d.rdata[hdc_pkg::P_RAILEN] = s_q.cfg.railDetEn;
        end
        hdc_pkg::OFS_MANDAC:
        begin
          s_d.rdata[hdc_pkg::P_MANVAL +: 10] = s_q.cfg.manualDac;
          s_d.rdata[hdc_pkg::P_MANEN] = s_q.cfg.manualEn;
          s_d.rdata[hdc_pkg::P_EXITCNT +: 14] = s_q.cfg.exitCount;
          s_d.rdata[hdc_pkg::P_FORCE] = s_q.cfg.forceHold;
        end
        hdc_pkg::OFS_XTAL:
        begin
          s_d.rdata[hdc_pkg::P_XTAL +: 2] = s_q.cfg.xtalLvl;
        end
        hdc_pkg::OFS_DACRB:
        begin
          s_d.rdata[hdc_pkg::P_DACRB +: 10] = s_q.dac;
        end
        hdc_pkg::OFS_FILTER:
        begin
          s_d.rdata[hdc_pkg::P_C4 +: 4] = s_q.cfg.capC4;
          s_d.rdata[hdc_pkg::P_C3 +: 4] = s_q.cfg.capC3;
          s_d.rdata[hdc_pkg::P_R4 +: 3] = s_q.cfg.resR4;
          s_d.rdata[hdc_pkg::P_R3 +: 3] = s_q.cfg.resR3;
        end
        hdc_pkg::OFS_STATUS:
        begin
          s_d.rdata[3:0] = {lockQualified, highFlag, lowFlag,
                            s_q.mode == hdc_pkg::HDC_HOLD};
        end
        default:
        begin
          s_d.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s_q.cfg <= hdc_pkg::CFG_RESET;
      s_q.mode <= hdc_pkg::HDC_TRACK;
      s_q.dac <= 10'h000;
      s_q.lockPrev <= 1'b0;
      s_q.railPrev <= 1'b0;
      s_q.swEvt <= 1'b0;
      s_q.rdata <= 32'h0000_0000;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Zero wait states; a write to the readback or status word is refused.
  assign pready = 1'b1;
  assign pslverr = psel && penable &&
                   (pwrite ? !writable(paddr) : !mapped(paddr));
  assign prdata = s_q.rdata;
  assign cfgOut = s_q.cfg;
  assign dacValue = s_q.dac;
  assign holdoverActive = s_q.mode == hdc_pkg::HDC_HOLD;
  assign switchEvent = s_q.swEvt;
  assign dacLowFlag = lowFlag;
  assign dacHighFlag = highFlag;

  a_pin_type_legal: assert property (@(posedge sys_clk) disable iff (rst)
    s_q.cfg.pinType <= 3'h6) else $error("pin type reserved");

  a_force_enters_hold: assert property (@(posedge sys_clk) disable iff (rst)
    s_q.cfg.forceHold |=> holdoverActive)
    else $error("force did not hold");

  a_manual_drives_dac: assert property (@(posedge sys_clk) disable iff (rst)
    s_q.cfg.manualEn |=> dacValue == $past(s_q.cfg.manualDac))
    else $error("manual value not driven");

  a_hold_keeps_dac: assert property (@(posedge sys_clk) disable iff (rst)
    holdoverActive && !s_q.cfg.manualEn |=> $stable(dacValue))
    else $error("dac moved in holdover");

  a_track_follows: assert property (@(posedge sys_clk) disable iff (rst)
    !holdoverActive && s_q.cfg.trackEn && !s_q.cfg.manualEn
    |=> dacValue == $past(trackedDac))
    else $error("dac not tracking");

  a_rail_switches: assert property (@(posedge sys_clk) disable iff (rst)
    railRise |=> switchEvent && holdoverActive)
    else $error("rail trip lost");

  a_lockdis_quiet: assert property (@(posedge sys_clk) disable iff (rst)
    s_q.cfg.lockLossDis && !railRise |=> !switchEvent)
    else $error("switch despite disable");

  a_force_no_event: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(s_q.cfg.forceHold) && !railRise && !lockFall |=> !switchEvent)
    else $error("force made a switch");

  a_exit_qualified: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(holdoverActive) |-> $past(lockQualified, 1))
    else $error("early holdover exit");

  a_readback_count: assert property (@(posedge sys_clk) disable iff (rst)
    setup && paddr == hdc_pkg::OFS_DACRB
    |=> prdata[23:14] == $past(s_q.dac))
    else $error("bad dac readback");

  a_c4_reserved: assert property (@(posedge sys_clk) disable iff (rst)
    wrAcc && paddr == hdc_pkg::OFS_FILTER && pwdata[31:28] > 4'hD
    |=> $stable(s_q.cfg.capC4))
    else $error("reserved c4 stored");

  c_forced_hold: cover property (@(posedge sys_clk) disable iff (rst)
    $rose(holdoverActive) && s_q.cfg.forceHold);
  c_rail_event: cover property (@(posedge sys_clk) disable iff (rst)
    railRise ##1 switchEvent);
  c_hold_exit: cover property (@(posedge sys_clk) disable iff (rst)
    $fell(holdoverActive));
  c_lock_loss: cover property (@(posedge sys_clk) disable iff (rst)
    lockFall && !s_q.cfg.lockLossDis ##1 switchEvent);
endmodule // hdc_holdover_dac_config_bank

// >>> sim/hdc_loop_model.sv
`timescale 1ns/10ps
// Reference loop stand-in: lock level, tuning level and a detector tick.
module hdc_loop_model
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic lockReq,
  input wire logic [9:0] tuneReq,
  output logic lockFlag,
  output logic pdTick,
  output logic [9:0] trackedDac
);
  logic [1:0] divCnt;

  // The detector ticks once every four system clocks.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      divCnt <= 2'h0;
      pdTick <= 1'b0;
      lockFlag <= 1'b0;
      trackedDac <= 10'h200;
    end
    else
    begin
      divCnt <= divCnt + 2'h1;
      pdTick <= (divCnt == 2'h3);
      lockFlag <= lockReq;
      trackedDac <= tuneReq;
    end
  end
endmodule // hdc_loop_model

// >>> sim/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [hdc_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic lockReq, lockFlag, pdTick, err;
  logic [9:0] tuneReq, trackedDac, dacValue;
  logic holdoverActive, switchEvent, dacLowFlag, dacHighFlag;
  hdc_pkg::hdc_cfg_s cfgOut;
  int n_errors, comparisons, evCount;

  hdc_loop_model loop (.sys_clk(sys_clk), .rst(rst), .lockReq(lockReq),
    .tuneReq(tuneReq), .lockFlag(lockFlag), .pdTick(pdTick),
    .trackedDac(trackedDac));

  hdc_holdover_dac_config_bank dut (.sys_clk(sys_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .refLoopLockFlag(lockFlag), .pdTick(pdTick), .trackedDac(trackedDac),
    .cfgOut(cfgOut), .dacValue(dacValue), .holdoverActive(holdoverActive),
    .switchEvent(switchEvent), .dacLowFlag(dacLowFlag),
    .dacHighFlag(dacHighFlag));

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      evCount <= 0;
    else if (switchEvent === 1'b1)
      evCount <= evCount + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int t;
    t = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      t++;
    end
    while (pready !== 1'b1 && t < 50);
    if (pready !== 1'b1)
      n_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic waitHold(input logic v);
    int t;
    t = 0;
    while (holdoverActive !== v && t < 60)
    begin
      @(posedge sys_clk);
      t++;
    end
    #1;
    chk({31'h0, holdoverActive}, {31'h0, v});
  endtask

  task automatic wrap_up;
    if (n_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    #50000;
    n_errors++;
    wrap_up();
  end

  initial
  begin
    n_errors = 0;
    comparisons = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    lockReq = 1'b1;
    tuneReq = 10'h200;
    cyc(10);
    rst <= 1'b0;
    rdchk(hdc_pkg::OFS_TRIP, 32'h0000_0000);
    rdchk(hdc_pkg::OFS_MANDAC, 32'h0000_0040);
    rdchk(hdc_pkg::OFS_FILTER, 32'h0000_0000);
    apb(1'b1, hdc_pkg::OFS_TRIP, 32'h062A_8540);
    rdchk(hdc_pkg::OFS_TRIP, 32'h062A_8540);
    apb(1'b1, hdc_pkg::OFS_TRIP, 32'h0710_0000);
    chk({31'h0, err}, 32'h0);
    rdchk(hdc_pkg::OFS_TRIP, 32'h0610_0000);
    chk({29'h0, cfgOut.pinType}, 32'h6);
    apb(1'b1, hdc_pkg::OFS_XTAL, 32'hC000_0000);
    rdchk(hdc_pkg::OFS_XTAL, 32'hC000_0000);
    apb(1'b1, hdc_pkg::OFS_FILTER, 32'hDD42_0000);
    rdchk(hdc_pkg::OFS_FILTER, 32'hDD42_0000);
    apb(1'b1, hdc_pkg::OFS_FILTER, 32'hEF53_0000);
    rdchk(hdc_pkg::OFS_FILTER, 32'hDD43_0000);
    apb(1'b1, hdc_pkg::OFS_DACRB, 32'hFFFF_FFFF);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 12'h100, 32'h0000_0001);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, hdc_pkg::OFS_TRIP, 32'h0000_0000);
    apb(1'b1, hdc_pkg::OFS_TRACK, 32'h0000_0100);
    apb(1'b1, hdc_pkg::OFS_LOCKDIS, 32'h0000_8000);
    tuneReq <= 10'h2A5;
    cyc(6);
    chk({22'h0, dacValue}, 32'h0000_02A5);
    rdchk(hdc_pkg::OFS_DACRB, 32'h00A9_4000);
    apb(1'b1, hdc_pkg::OFS_MANDAC, 32'h5550_00C0);
    cyc(3);
    chk({22'h0, dacValue}, 32'h0000_0155);
    apb(1'b1, hdc_pkg::OFS_MANDAC, 32'h0000_00C0);
    cyc(3);
    chk({22'h0, dacValue}, 32'h0000_02A5);
    apb(1'b1, hdc_pkg::OFS_MANDAC, 32'h0000_00E0);
    waitHold(1'b1);
    tuneReq <= 10'h100;
    cyc(6);
    chk({22'h0, dacValue}, 32'h0000_02A5);
    rdchk(hdc_pkg::OFS_STATUS, 32'h0000_0009);
    apb(1'b1, hdc_pkg::OFS_MANDAC, 32'h5550_00E0);
    cyc(3);
    chk({22'h0, dacValue}, 32'h0000_0155);
    chk(evCount, 32'h0);
    lockReq <= 1'b0;
    cyc(6);
    chk(evCount, 32'h0);
    lockReq <= 1'b1;
    apb(1'b1, hdc_pkg::OFS_LOCKDIS, 32'h0000_0000);
    cyc(12);
    lockReq <= 1'b0;
    cyc(6);
    chk(evCount, 32'h1);
    apb(1'b1, hdc_pkg::OFS_LOCKDIS, 32'h0000_8000);
    apb(1'b1, hdc_pkg::OFS_MANDAC, 32'h0000_00C0);
    cyc(20);
    chk({31'h0, holdoverActive}, 32'h1);
    lockReq <= 1'b1;
    cyc(4);
    chk({31'h0, holdoverActive}, 32'h1);
    waitHold(1'b0);
    tuneReq <= 10'h005;
    apb(1'b1, hdc_pkg::OFS_TRIP, 32'h0000_0020);
    waitHold(1'b1);
    chk({31'h0, dacLowFlag}, 32'h1);
    chk({31'h0, dacHighFlag}, 32'h0);
    chk(evCount, 32'h2);
    apb(1'b1, hdc_pkg::OFS_MANDAC, 32'hFFD0_00C0);
    cyc(4);
    chk({31'h0, dacHighFlag}, 32'h1);
    chk({31'h0, dacLowFlag}, 32'h0);
    chk(evCount, 32'h2);
    rdchk(hdc_pkg::OFS_STATUS, 32'h0000_000D);
    wrap_up();
  end
endmodule // testbench
